// ---- pkg/tsr_consts.svh ----
// Purpose: named constants of the temperature sensor readout
// Assumes: included by bare name
// Notes: times in their own units, cycles derived in the logic
`ifndef TSR_CONSTS_SVH
`define TSR_CONSTS_SVH
`define TSR_CLK_HZ 20000000
`define TSR_MS_PER_S 1000
`define TSR_LOCAL_MS 14
`define TSR_REMOTE_MS 26
`define TSR_PER_R1_MS 200
`define TSR_PER_R2_MS 1000
`define TSR_PER_R3_MS 3000
`define TSR_TIMEOUT_MS 35
`define TSR_SLAVE_ADDR 7'h2B
`define TSR_ACK_IDX 4'h8
`define TSR_REG_STATUS 8'h02
`define TSR_REG_CONFIG 8'h03
`define TSR_REG_ONESHOT 8'h0F
`define TSR_REG_MSB_LO 8'h10
`define TSR_REG_MSB_HI 8'h12
`define TSR_REG_LSB_LO 8'h20
`define TSR_REG_LSB_HI 8'h22
`define TSR_REG_MFG_ID 8'hFE
`define TSR_REG_REV_ID 8'hFF
`define TSR_PTR_RESET 8'h00
`define TSR_CFG_RESET 8'h00
`define TSR_CFG_MASK 8'h76
`define TSR_CFG_STANDBY 6
`define TSR_CFG_RATE_HI 5
`define TSR_CFG_RATE_LO 4
`define TSR_CFG_R2FMT 2
`define TSR_CFG_R1FMT 1
`define TSR_RATE_CONT 2'h0
`define TSR_RATE_R1 2'h1
`define TSR_RATE_R2 2'h2
`define TSR_REM_FAULT_SIGNED 16'h8000
`define TSR_REM_FAULT_UNSIGNED 16'hFFE0
`define TSR_SIGNED_MAX 12'sh3FF
`define TSR_SIGNED_MIN 12'shC00
`define TSR_UNSIGNED_MAX 12'sh7FF
`define TSR_ZERO_BYTE 8'h00
`endif

// ---- pkg/tsr_pkg.sv ----
// Purpose: types of the temperature sensor readout
// Assumes: nothing
// Notes: constants live in tsr_consts.svh
package tsr_pkg;
  typedef enum logic [2:0] {
    TSR_CV_IDLE = 3'b000,
    TSR_CV_LOCAL = 3'b001,
    TSR_CV_REM1 = 3'b010,
    TSR_CV_REM2 = 3'b011,
    TSR_CV_WAIT = 3'b100
  } tsr_conv_state_t;

  typedef enum logic [2:0] {
    TSR_LK_ADDR = 3'b000,
    TSR_LK_PTR = 3'b001,
    TSR_LK_WDATA = 3'b010,
    TSR_LK_READ = 3'b011,
    TSR_LK_IGNORE = 3'b100
  } tsr_link_phase_t;

  // one finished measurement cycle of all three zones from the analog front end
  typedef struct packed {
    logic [9:0] local_code;
    logic signed [11:0] remote1;
    logic signed [11:0] remote2;
    logic fault1;
    logic fault2;
  } tsr_fe_sample_t;

  // zone request towards the analog front end
  typedef struct packed {
    logic active;
    logic [1:0] zone;
  } tsr_fe_req_t;
endpackage

// ---- logic/tsr_sensor.sv ----
// Purpose: conversion sequencer, result registers and bus slave
// Assumes: front end runs on clk; smb_clk is the host bus clock
// Notes: read data handed over inside the bus clock high time
`timescale 1ns/1ns
`include "tsr_consts.svh"

module tsr_sensor #(
  parameter int LOCAL_CYC = `TSR_LOCAL_MS * (`TSR_CLK_HZ / `TSR_MS_PER_S),
  parameter int REMOTE_CYC = `TSR_REMOTE_MS * (`TSR_CLK_HZ / `TSR_MS_PER_S),
  parameter int PER_R1_CYC = `TSR_PER_R1_MS * (`TSR_CLK_HZ / `TSR_MS_PER_S),
  parameter int PER_R2_CYC = `TSR_PER_R2_MS * (`TSR_CLK_HZ / `TSR_MS_PER_S),
  parameter int PER_R3_CYC = `TSR_PER_R3_MS * (`TSR_CLK_HZ / `TSR_MS_PER_S),
  parameter int TIMEOUT_CYC = `TSR_TIMEOUT_MS * (`TSR_CLK_HZ / `TSR_MS_PER_S),
  parameter logic [7:0] MFG_ID = 8'h5A, // arbitrary value
  parameter logic [7:0] REV_ID = 8'h3C  // arbitrary value
) (
  // system
  input wire logic clk,
  input wire logic rst_b,
  // bus pins
  input wire logic smb_clk,
  input wire logic smb_dat_in,
  output logic smb_dat_out,
  output logic smb_dat_oe_b,
  // analog front end
  input wire logic fe_done,
  input wire tsr_pkg::tsr_fe_sample_t fe_sample,
  output tsr_pkg::tsr_fe_req_t fe_req
);
  localparam int CONV_CYC = LOCAL_CYC + 2 * REMOTE_CYC;
  localparam int CNT_W = $clog2(PER_R3_CYC + 1);
  localparam int TO_W = $clog2(TIMEOUT_CYC + 1);

  if (LOCAL_CYC < 1 || REMOTE_CYC < 1 || TIMEOUT_CYC < 2 ||
      PER_R1_CYC <= CONV_CYC + 1 || PER_R2_CYC < PER_R1_CYC ||
      PER_R3_CYC < PER_R2_CYC)
  begin : g_bad_param
    $error("tsr_sensor: cycle counts cannot be served");
  end

  // bus level synchronisers and edges
  logic scl_s1_q, scl_s2_q, scl_s3_q;
  logic sda_s1_q, sda_s2_q, sda_s3_q;
  logic [TO_W-1:0] to_cnt_q;
  logic restart_q, start_seen_q;
  wire bus_start = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
  wire bus_stop = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;
  wire bus_low = ~scl_s2_q | ~sda_s2_q;
  wire to_hit = (to_cnt_q == TO_W'(TIMEOUT_CYC));

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      scl_s3_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_s3_q <= 1'b1;
    end
    else
    begin
      scl_s1_q <= smb_clk;
      scl_s2_q <= scl_s1_q;
      scl_s3_q <= scl_s2_q;
      sda_s1_q <= smb_dat_in;
      sda_s2_q <= sda_s1_q;
      sda_s3_q <= sda_s2_q;
    end
  end

  // bus timeout counter and link restart
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      to_cnt_q <= '0;
    else if (!bus_low)
      to_cnt_q <= '0;
    else if (!to_hit)
      to_cnt_q <= to_cnt_q + 1'b1;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      restart_q <= 1'b1;
      start_seen_q <= 1'b0;
    end
    else if (bus_start)
    begin
      restart_q <= 1'b1;
      start_seen_q <= 1'b1;
    end
    else if (bus_stop || to_hit)
    begin
      restart_q <= 1'b1;
      start_seen_q <= 1'b0;
    end
    else if (start_seen_q && !scl_s2_q)
      restart_q <= 1'b0;
  end

  // link side, bus clock domain
  logic [3:0] bcnt_q;
  logic [7:0] shreg_q, ptr_q, wr_data_q, tx_q, rd_data_q;
  logic rd_t_q, wr_t_q, oe_b_q;
  tsr_pkg::tsr_link_phase_t phase_q;
  wire lnk_rst_b = rst_b & ~restart_q;
  wire ack_bit = (bcnt_q == `TSR_ACK_IDX);
  wire addr_hit = (shreg_q[7:1] == `TSR_SLAVE_ADDR);
  wire in_addr = (phase_q == tsr_pkg::TSR_LK_ADDR);
  wire in_read = (phase_q == tsr_pkg::TSR_LK_READ);
  wire rd_go = ack_bit & ((in_addr & addr_hit & shreg_q[0]) |
                          (in_read & ~smb_dat_in));
  wire wr_go = ack_bit & (phase_q == tsr_pkg::TSR_LK_WDATA);
  wire ptr_go = ack_bit & (phase_q == tsr_pkg::TSR_LK_PTR);
  wire ack_drive = (in_addr & addr_hit) | wr_go | ptr_go;

  always_ff @(posedge smb_clk or negedge lnk_rst_b)
  begin
    if (!lnk_rst_b)
    begin
      bcnt_q <= '0;
      shreg_q <= '0;
      phase_q <= tsr_pkg::TSR_LK_ADDR;
    end
    else if (!ack_bit)
    begin
      bcnt_q <= bcnt_q + 1'b1;
      shreg_q <= {shreg_q[6:0], smb_dat_in};
    end
    else
    begin
      bcnt_q <= '0;
      unique case (phase_q)
        tsr_pkg::TSR_LK_ADDR:
          if (!addr_hit)
            phase_q <= tsr_pkg::TSR_LK_IGNORE;
          else if (shreg_q[0])
            phase_q <= tsr_pkg::TSR_LK_READ;
          else
            phase_q <= tsr_pkg::TSR_LK_PTR;
        tsr_pkg::TSR_LK_PTR:
          phase_q <= tsr_pkg::TSR_LK_WDATA;
        tsr_pkg::TSR_LK_WDATA:
          phase_q <= tsr_pkg::TSR_LK_IGNORE;
        tsr_pkg::TSR_LK_READ:
          if (smb_dat_in)
            phase_q <= tsr_pkg::TSR_LK_IGNORE;
        tsr_pkg::TSR_LK_IGNORE:
          phase_q <= tsr_pkg::TSR_LK_IGNORE;
        default:
          phase_q <= tsr_pkg::TSR_LK_IGNORE;
      endcase
    end
  end

  // pointer and event toggles survive bus restarts
  always_ff @(posedge smb_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ptr_q <= `TSR_PTR_RESET;
      wr_data_q <= '0;
      rd_t_q <= 1'b0;
      wr_t_q <= 1'b0;
    end
    else
    begin
      if (ptr_go)
        ptr_q <= shreg_q;
      if (wr_go)
      begin
        wr_data_q <= shreg_q;
        wr_t_q <= ~wr_t_q;
      end
      if (rd_go)
        rd_t_q <= ~rd_t_q;
    end
  end

  // falling edge: ack and read data, open drain
  always_ff @(negedge smb_clk or negedge lnk_rst_b)
  begin
    if (!lnk_rst_b)
    begin
      tx_q <= '0;
      oe_b_q <= 1'b1;
    end
    else if (ack_bit)
    begin
      tx_q <= tx_q;
      oe_b_q <= ~ack_drive;
    end
    else if (in_read && bcnt_q == 4'h0)
    begin
      tx_q <= {rd_data_q[6:0], 1'b0};
      oe_b_q <= rd_data_q[7];
    end
    else if (in_read)
    begin
      tx_q <= {tx_q[6:0], 1'b0};
      oe_b_q <= tx_q[7];
    end
    else
    begin
      tx_q <= tx_q;
      oe_b_q <= 1'b1;
    end
  end

  assign smb_dat_out = 1'b0;
  assign smb_dat_oe_b = oe_b_q;

  // event toggles into clk domain
  logic rd_t1_q, rd_t2_q, rd_t3_q, wr_t1_q, wr_t2_q, wr_t3_q;
  wire rd_evt = rd_t2_q ^ rd_t3_q;
  wire wr_evt = wr_t2_q ^ wr_t3_q;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rd_t1_q <= 1'b0;
      rd_t2_q <= 1'b0;
      rd_t3_q <= 1'b0;
      wr_t1_q <= 1'b0;
      wr_t2_q <= 1'b0;
      wr_t3_q <= 1'b0;
    end
    else
    begin
      rd_t1_q <= rd_t_q;
      rd_t2_q <= rd_t1_q;
      rd_t3_q <= rd_t2_q;
      wr_t1_q <= wr_t_q;
      wr_t2_q <= wr_t1_q;
      wr_t3_q <= wr_t2_q;
    end
  end

  // register file
  logic [7:0] cfg_q;
  logic [15:0] res_q [3];
  logic [7:0] lsb_hold_q [3];
  logic [2:0] lock_q;
  logic [1:0] miss_q;
  logic oneshot_q;
  tsr_pkg::tsr_conv_state_t cv_q;
  logic [CNT_W-1:0] cv_cnt_q;

  wire standby = cfg_q[`TSR_CFG_STANDBY];
  wire [1:0] rate = cfg_q[`TSR_CFG_RATE_HI:`TSR_CFG_RATE_LO];
  wire busy = (cv_q != tsr_pkg::TSR_CV_IDLE) && (cv_q != tsr_pkg::TSR_CV_WAIT);
  wire [7:0] status = {busy, 5'h00, miss_q};
  wire [1:0] ch = ptr_q[1:0];
  wire msb_sel = (ptr_q == `TSR_PTR_RESET) ||
    ((ptr_q >= `TSR_REG_MSB_LO) && (ptr_q <= `TSR_REG_MSB_HI));
  wire lsb_sel = (ptr_q >= `TSR_REG_LSB_LO) && (ptr_q <= `TSR_REG_LSB_HI);
  wire [7:0] lsb_view = lock_q[ch] ? lsb_hold_q[ch] : res_q[ch][7:0];
  wire [7:0] rd_mux =
    msb_sel ? res_q[ch][15:8] :
    lsb_sel ? lsb_view :
    (ptr_q == `TSR_REG_STATUS) ? status :
    (ptr_q == `TSR_REG_CONFIG) ? cfg_q :
    (ptr_q == `TSR_REG_MFG_ID) ? MFG_ID :
    (ptr_q == `TSR_REG_REV_ID) ? REV_ID :
    `TSR_ZERO_BYTE;
  wire cfg_wr = wr_evt && (ptr_q == `TSR_REG_CONFIG);
  wire shot_wr = wr_evt && (ptr_q == `TSR_REG_ONESHOT) && standby;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      cfg_q <= `TSR_CFG_RESET;
    else if (cfg_wr)
      cfg_q <= wr_data_q & `TSR_CFG_MASK;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      rd_data_q <= '0;
    else if (rd_evt)
      rd_data_q <= rd_mux;
  end

  for (genvar i = 0; i < 3; i++)
  begin : g_lock
    always_ff @(posedge clk or negedge rst_b)
    begin
      if (!rst_b)
      begin
        lock_q[i] <= 1'b0;
        lsb_hold_q[i] <= '0;
      end
      else if (rd_evt && msb_sel && ch == 2'(i))
      begin
        lock_q[i] <= 1'b1;
        lsb_hold_q[i] <= res_q[i][7:0];
      end
      else if (rd_evt && lsb_sel && ch == 2'(i))
        lock_q[i] <= 1'b0;
    end
  end

  // remote word with format and fault handling
  function automatic logic [15:0] rem_word(
    input logic signed [11:0] t,
    input logic fault,
    input logic signed_fmt
  );
    logic signed [11:0] c;
    c = t;
    if (signed_fmt)
    begin
      if (t > `TSR_SIGNED_MAX)
        c = `TSR_SIGNED_MAX;
      else if (t < `TSR_SIGNED_MIN)
        c = `TSR_SIGNED_MIN;
    end
    else
    begin
      if (t < 12'sh000)
        c = 12'sh000;
      else if (t > `TSR_UNSIGNED_MAX)
        c = `TSR_UNSIGNED_MAX;
    end
    if (fault)
      rem_word = signed_fmt ? `TSR_REM_FAULT_SIGNED : `TSR_REM_FAULT_UNSIGNED;
    else
      rem_word = {c[10:0], 5'h00};
  endfunction

  // conversion sequencer
  logic [CNT_W-1:0] idle_len;
  always_comb
  begin
    unique case (rate)
      `TSR_RATE_CONT: idle_len = '0;
      `TSR_RATE_R1: idle_len = CNT_W'(PER_R1_CYC - CONV_CYC - 2);
      `TSR_RATE_R2: idle_len = CNT_W'(PER_R2_CYC - CONV_CYC - 2);
      default: idle_len = CNT_W'(PER_R3_CYC - CONV_CYC - 2);
    endcase
  end

  wire slot_end = (cv_cnt_q == '0);
  wire go = ~standby | oneshot_q;
  wire fmt1 = cfg_q[`TSR_CFG_R1FMT];
  wire fmt2 = cfg_q[`TSR_CFG_R2FMT];

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      oneshot_q <= 1'b0;
    else if (shot_wr)
      oneshot_q <= 1'b1;
    else if (cv_q == tsr_pkg::TSR_CV_IDLE && go)
      oneshot_q <= 1'b0;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cv_q <= tsr_pkg::TSR_CV_IDLE;
      cv_cnt_q <= '0;
    end
    else
    begin
      unique case (cv_q)
        tsr_pkg::TSR_CV_IDLE:
          if (go)
          begin
            cv_q <= tsr_pkg::TSR_CV_LOCAL;
            cv_cnt_q <= CNT_W'(LOCAL_CYC - 1);
          end
        tsr_pkg::TSR_CV_LOCAL:
          if (slot_end)
          begin
            cv_q <= tsr_pkg::TSR_CV_REM1;
            cv_cnt_q <= CNT_W'(REMOTE_CYC - 1);
          end
          else
            cv_cnt_q <= cv_cnt_q - 1'b1;
        tsr_pkg::TSR_CV_REM1:
          if (slot_end)
          begin
            cv_q <= tsr_pkg::TSR_CV_REM2;
            cv_cnt_q <= CNT_W'(REMOTE_CYC - 1);
          end
          else
            cv_cnt_q <= cv_cnt_q - 1'b1;
        tsr_pkg::TSR_CV_REM2:
          if (slot_end && (standby || rate == `TSR_RATE_CONT))
            cv_q <= tsr_pkg::TSR_CV_IDLE;
          else if (slot_end)
          begin
            cv_q <= tsr_pkg::TSR_CV_WAIT;
            cv_cnt_q <= idle_len;
          end
          else
            cv_cnt_q <= cv_cnt_q - 1'b1;
        tsr_pkg::TSR_CV_WAIT:
          if (slot_end || standby)
            cv_q <= tsr_pkg::TSR_CV_IDLE;
          else
            cv_cnt_q <= cv_cnt_q - 1'b1;
        default:
          cv_q <= tsr_pkg::TSR_CV_IDLE;
      endcase
    end
  end

  // results captured at each slot end
  wire local_end = (cv_q == tsr_pkg::TSR_CV_LOCAL) && slot_end;
  wire rem1_end = (cv_q == tsr_pkg::TSR_CV_REM1) && slot_end;
  wire rem2_end = (cv_q == tsr_pkg::TSR_CV_REM2) && slot_end;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      res_q[0] <= '0;
      res_q[1] <= '0;
      res_q[2] <= '0;
      miss_q <= '0;
    end
    else
    begin
      if (local_end)
        res_q[0] <= {fe_sample.local_code, 6'h00};
      if (rem1_end)
      begin
        res_q[1] <= rem_word(fe_sample.remote1, fe_sample.fault1, fmt1);
        miss_q[0] <= fe_sample.fault1;
      end
      if (rem2_end)
      begin
        res_q[2] <= rem_word(fe_sample.remote2, fe_sample.fault2, fmt2);
        miss_q[1] <= fe_sample.fault2;
      end
    end
  end

  // zone request to the front end
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      fe_req <= '0;
    else
    begin
      fe_req.active <= busy;
      fe_req.zone <= cv_q[1:0] - 2'h1;
    end
  end

  wire unused_fe_done = fe_done;
endmodule

// ---- tb/tsr_sensor_asserts.sv ----
// Purpose: port checker of the sensor readout
// Assumes: bound to tsr_sensor, one clk domain for sampling
// Notes: bus pins are sampled on clk
`timescale 1ns/1ns
module tsr_sensor_asserts #(
  parameter int LOCAL_CYC = 20,
  parameter int REMOTE_CYC = 30,
  parameter int TIMEOUT_CYC = 1000
) (
  // system
  input wire logic clk,
  input wire logic rst_b,
  // bus pins
  input wire logic smb_clk,
  input wire logic smb_dat_in,
  input wire logic smb_dat_out,
  input wire logic smb_dat_oe_b,
  // front end
  input wire logic fe_done,
  input wire tsr_pkg::tsr_fe_sample_t fe_sample,
  input wire tsr_pkg::tsr_fe_req_t fe_req
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  logic [1:0] zone_q;
  int slot_q;
  int low_q;
  wire zone_new = fe_req.zone != zone_q;

  // slot length and data pull-down length
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      zone_q <= 2'h0;
      slot_q <= 0;
      low_q <= 0;
    end
    else
    begin
      zone_q <= fe_req.zone;
      slot_q <= (!fe_req.active || zone_new) ? 0 : slot_q + 1;
      low_q <= smb_dat_oe_b ? 0 : low_q + 1;
    end
  end

  chk_dat_low_only:
    assert property (smb_dat_out == 1'b0)
    else $error("data pin driven high");
  chk_oe_clk_high:
    assert property (smb_clk && $past(smb_clk) |-> $stable(smb_dat_oe_b))
    else $error("data drive changed while bus clock high");
  chk_zone_valid:
    assert property (fe_req.active |-> fe_req.zone != 2'h3)
    else $error("unknown zone requested");
  chk_zone_order:
    assert property (fe_req.active && $past(fe_req.active) && zone_new |->
      fe_req.zone == ((zone_q == 2'h2) ? 2'h0 : zone_q + 2'h1))
    else $error("zone order broken");
  chk_local_first:
    assert property ($rose(fe_req.active) |-> (fe_req.zone == 2'h0) [*8])
    else $error("cycle did not begin with local zone");
  chk_local_slot:
    assert property (fe_req.active && zone_q == 2'h0 && fe_req.zone == 2'h1 |->
      slot_q + 3 >= LOCAL_CYC && slot_q <= LOCAL_CYC + 2)
    else $error("local slot length wrong");
  chk_remote_slot:
    assert property (fe_req.active |-> slot_q <= REMOTE_CYC + 2)
    else $error("slot too long");
  chk_timeout_free:
    assert property (low_q <= TIMEOUT_CYC + 8)
    else $error("data held low past timeout");
  chk_reset_quiet:
    assert property (@(posedge clk) disable iff (1'b0)
      !rst_b |-> smb_dat_oe_b && fe_req == '0)
    else $error("outputs active in reset");

  cov_cycle: cover property ($rose(fe_req.active));
  cov_drive: cover property ($fell(smb_dat_oe_b));
  cov_remote2: cover property (fe_req.active && fe_req.zone == 2'h2);
endmodule

bind tsr_sensor tsr_sensor_asserts #(
  .LOCAL_CYC(LOCAL_CYC),
  .REMOTE_CYC(REMOTE_CYC),
  .TIMEOUT_CYC(TIMEOUT_CYC)
) i_tsr_sensor_asserts (
  .clk(clk),
  .rst_b(rst_b),
  .smb_clk(smb_clk),
  .smb_dat_in(smb_dat_in),
  .smb_dat_out(smb_dat_out),
  .smb_dat_oe_b(smb_dat_oe_b),
  .fe_done(fe_done),
  .fe_sample(fe_sample),
  .fe_req(fe_req)
);

// ---- tb/tsr_host.sv ----
// Purpose: bus host model, drives clock and data
// Assumes: data wire resolved by the bench with a pull-up
// Notes: phase of eleven 80 ns link ticks
`timescale 1ns/1ns
module tsr_host (
  // bus
  output logic scl,
  output logic sda_drv,
  input wire logic sda
);
  localparam int T = 880;
  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // data set in clock low, sampled mid high
  task automatic bit_io(input logic b, output logic r);
    #(T / 4);
    sda_drv = b;
    #(T - T / 4);
    scl = 1'b1;
    #(T / 2);
    r = sda;
    #(T / 2);
    scl = 1'b0;
  endtask
  // start or repeated start
  task automatic start();
    #(T / 4);
    sda_drv = 1'b1;
    #(T - T / 4);
    scl = 1'b1;
    #T;
    sda_drv = 1'b0;
    #T;
    scl = 1'b0;
  endtask
  task automatic stop();
    #(T / 4);
    sda_drv = 1'b0;
    #(T - T / 4);
    scl = 1'b1;
    #T;
    sda_drv = 1'b1;
    #T;
  endtask
  // address, pointer or data byte
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic get_byte(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, b[i]);
    bit_io(last, r);
  endtask
  // clock kept low past the bus timeout
  task automatic hold_low(input int ns);
    #(ns);
  endtask
endmodule

// ---- tb/tsr_sensor_bench.sv ----
// Purpose: self-checking bench of the sensor readout
// Assumes: small slot, period and timeout parameters
// Notes: host model drives the bus, bench drives the front end
`timescale 1ns/1ns
module tsr_sensor_bench;
  localparam int TMO = 1000;
  localparam int PER[3] = '{200, 300, 400};
  localparam logic [7:0] AW = 8'h56;
  localparam logic [7:0] AR = 8'h57;
  logic clk = 1'b0;
  logic rst_b = 1'b1;
  logic scl;
  logic host_sda;
  logic smb_dat_out;
  logic smb_dat_oe_b;
  wire sda = host_sda & (smb_dat_oe_b | smb_dat_out);
  tsr_pkg::tsr_fe_sample_t fe_sample = '0;
  tsr_pkg::tsr_fe_req_t fe_req;
  int num_errors = 0;
  int n_tests = 0;
  int cycles = 0;
  int n;
  logic ack;
  logic [7:0] rd;

  always #25 clk = ~clk;

  tsr_sensor #(
    .LOCAL_CYC(20),
    .REMOTE_CYC(30),
    .PER_R1_CYC(PER[0]),
    .PER_R2_CYC(PER[1]),
    .PER_R3_CYC(PER[2]),
    .TIMEOUT_CYC(TMO)
  ) i_tsr_sensor (
    .clk(clk),
    .rst_b(rst_b),
    .smb_clk(scl),
    .smb_dat_in(sda),
    .smb_dat_out(smb_dat_out),
    .smb_dat_oe_b(smb_dat_oe_b),
    .fe_done(1'b0),
    .fe_sample(fe_sample),
    .fe_req(fe_req)
  );
  tsr_host i_tsr_host (
    .scl(scl),
    .sda_drv(host_sda),
    .sda(sda)
  );

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  task automatic reg_wr(input logic [7:0] ptr, input logic [7:0] val);
    i_tsr_host.start();
    i_tsr_host.put_byte(AW, ack);
    check({7'h0, ack}, 8'h01);
    i_tsr_host.put_byte(ptr, ack);
    i_tsr_host.put_byte(val, ack);
    check({7'h0, ack}, 8'h01);
    i_tsr_host.stop();
  endtask
  task automatic reg_rd(input logic [7:0] ptr, input logic [7:0] exp);
    i_tsr_host.start();
    i_tsr_host.put_byte(AW, ack);
    i_tsr_host.put_byte(ptr, ack);
    i_tsr_host.start();
    i_tsr_host.put_byte(AR, ack);
    i_tsr_host.get_byte(1'b1, rd);
    i_tsr_host.stop();
    check(rd, exp);
  endtask
  task automatic rd_cur(input logic [7:0] exp);
    i_tsr_host.start();
    i_tsr_host.put_byte(AR, ack);
    i_tsr_host.get_byte(1'b0, rd);
    check(rd, exp);
    i_tsr_host.get_byte(1'b1, rd);
    check(rd, exp);
    i_tsr_host.stop();
  endtask
  task automatic set_fe(input logic [9:0] l, input logic [11:0] a, input logic [11:0] b,
    input logic f);
    @(negedge clk);
    fe_sample = '{l, a, b, f, f};
    repeat (200) @(negedge clk);
  endtask
  task automatic to_rise(output int k);
    logic prev;
    prev = 1'b1;
    k = 0;
    while (!(prev === 1'b0 && fe_req.active === 1'b1) && k < 1000)
    begin
      prev = fe_req.active;
      @(negedge clk);
      k++;
    end
  endtask

  initial
  begin
    #1;
    rst_b = 1'b0;
    repeat (20) @(negedge clk);
    rst_b = 1'b1;
    rd_cur(8'h00);
    reg_rd(8'h03, 8'h00);
    done("defaults");
    set_fe(10'h2C5, 12'h500, 12'hFFE, 1'b0);
    reg_rd(8'h10, 8'hB1);
    reg_rd(8'h20, 8'h40);
    reg_rd(8'h11, 8'hA0);
    reg_rd(8'h21, 8'h00);
    reg_rd(8'h12, 8'h00);
    reg_rd(8'h02, 8'h80);
    reg_wr(8'h03, 8'hFF);
    reg_rd(8'h03, 8'h76);
    reg_wr(8'h03, 8'h06);
    set_fe(10'h2C5, 12'h500, 12'hFFE, 1'b0);
    reg_rd(8'h12, 8'hFF);
    reg_rd(8'h22, 8'hC0);
    reg_rd(8'h11, 8'h7F);
    done("formats");
    set_fe(10'h2C5, 12'h002, 12'hFFE, 1'b0);
    reg_rd(8'h21, 8'hE0);
    reg_rd(8'h21, 8'h40);
    reg_rd(8'h11, 8'h00);
    set_fe(10'h2C5, 12'h500, 12'hFFE, 1'b0);
    reg_rd(8'h11, 8'h7F);
    set_fe(10'h2C5, 12'h002, 12'hFFE, 1'b0);
    reg_rd(8'h21, 8'hE0);
    done("lock");
    set_fe(10'h2C5, 12'h002, 12'hFFE, 1'b1);
    reg_rd(8'h11, 8'h80);
    reg_rd(8'h12, 8'h80);
    reg_rd(8'h02, 8'h83);
    reg_wr(8'h03, 8'h00);
    set_fe(10'h2C5, 12'h002, 12'hFFE, 1'b1);
    reg_rd(8'h11, 8'hFF);
    reg_rd(8'h21, 8'hE0);
    done("faults");
    set_fe(10'h2C5, 12'h002, 12'hFFE, 1'b0);
    reg_wr(8'h03, 8'h40);
    set_fe(10'h200, 12'h002, 12'hFFE, 1'b0);
    reg_rd(8'h02, 8'h00);
    reg_rd(8'h10, 8'hB1);
    reg_wr(8'h0F, 8'hAA);
    repeat (200) @(negedge clk);
    reg_rd(8'h10, 8'h80);
    reg_rd(8'h0F, 8'h00);
    done("standby");
    for (int i = 0; i < 3; i++)
    begin
      reg_wr(8'h03, 8'((i + 1) * 16));
      to_rise(n);
      to_rise(n);
      check({7'h0, n == PER[i]}, 8'h01);
    end
    done("rates");
    for (int i = 0; i < 7; i++)
    begin
      i_tsr_host.start();
      i_tsr_host.put_byte(AW ^ (8'h02 << i), ack);
      check({7'h0, ack}, 8'h00);
      i_tsr_host.stop();
    end
    i_tsr_host.start();
    i_tsr_host.put_byte(AW, ack);
    i_tsr_host.put_byte(8'h03, ack);
    i_tsr_host.put_byte(8'h06, ack);
    i_tsr_host.put_byte(8'h00, ack);
    check({7'h0, ack}, 8'h00);
    i_tsr_host.stop();
    rd_cur(8'h06);
    done("address");
    i_tsr_host.start();
    i_tsr_host.put_byte(AR, ack);
    i_tsr_host.hold_low(TMO * 60);
    check({7'h0, sda}, 8'h01);
    i_tsr_host.stop();
    rd_cur(8'h06);
    done("timeout");
    close_out();
  end

  // cuts a hang short
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      num_errors++;
      close_out();
    end
  end
endmodule
